// file: dram_pkg.sv
`default_nettype none
package dram_pkg;

	// clock and refresh figures
	localparam int CLK_PERIOD_NS  = 20;
	localparam int CLK_PER_MS     = 1000000 / CLK_PERIOD_NS;
	localparam int REF_STD_MS     = 2;
	localparam int REF_FAST_MS    = 1;
	localparam int REF_STD_DEF_CYC  = REF_STD_MS * CLK_PER_MS;
	localparam int REF_FAST_DEF_CYC = REF_FAST_MS * CLK_PER_MS;
	localparam int ROW_BITS       = 6;
	localparam int REF_ROWS       = 64;
	localparam int ADDR_BITS      = 12;
	localparam int REF_SLOT_BITS  = 16;

	// device timing in ns
	localparam int ACCESS_NS      = 300;
	localparam int READ_CE_MIN_NS = 280;
	localparam int WRITE_CE_MIN_NS = 480;
	localparam int RMW_CE_MIN_NS  = 620;
	localparam int CE_MAX_NS      = 3000;
	localparam int CE_OFF_NS      = 180;
	localparam int WE_OFF_NS      = 340;
	localparam int READ_CYCLE_NS  = 500;
	localparam int WRITE_CYCLE_NS = 700;
	localparam int RMW_CYCLE_NS   = 840;
	localparam int WRITE_WAIT_NS  = 0;
	localparam int WW_BAND_LO_NS  = 50;
	localparam int WW_BAND_HI_NS  = 170;

	// least times round up, longest times round down
	localparam int ACC_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CE_MIN_CYC =
		(READ_CE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_CE_MIN_CYC =
		(WRITE_CE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RMW_CE_MIN_CYC =
		(RMW_CE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CE_MAX_CYC = CE_MAX_NS / CLK_PERIOD_NS;
	localparam int CE_OFF_CYC = (CE_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WE_OFF_CYC = (WE_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYCLE_CYC =
		(READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_CYCLE_CYC =
		(WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RMW_CYCLE_CYC =
		(RMW_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_WAIT_CYC = WRITE_WAIT_NS / CLK_PERIOD_NS;
	localparam int WW_BAND_LO_CYC = WW_BAND_LO_NS / CLK_PERIOD_NS;
	localparam int WW_BAND_HI_CYC =
		(WW_BAND_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// strobe widths: read keeps strobe up past the sample edge
	localparam int READ_ON_CYC = (ACC_CYC + 1 > READ_CE_MIN_CYC) ?
		ACC_CYC + 1 : READ_CE_MIN_CYC;
	localparam int WRITE_ON_CYC = (WE_OFF_CYC > WRITE_CE_MIN_CYC) ?
		WE_OFF_CYC : WRITE_CE_MIN_CYC;
	localparam int RMW_ON_CYC = (ACC_CYC + WE_OFF_CYC > RMW_CE_MIN_CYC) ?
		ACC_CYC + WE_OFF_CYC : RMW_CE_MIN_CYC;
	localparam int READ_PRE_CYC = (READ_CYCLE_CYC - READ_ON_CYC > CE_OFF_CYC)
		? READ_CYCLE_CYC - READ_ON_CYC : CE_OFF_CYC;
	localparam int WRITE_PRE_CYC =
		(WRITE_CYCLE_CYC - WRITE_ON_CYC > CE_OFF_CYC)
		? WRITE_CYCLE_CYC - WRITE_ON_CYC : CE_OFF_CYC;
	localparam int RMW_PRE_CYC = (RMW_CYCLE_CYC - RMW_ON_CYC > CE_OFF_CYC)
		? RMW_CYCLE_CYC - RMW_ON_CYC : CE_OFF_CYC;

	typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_RMW} op_e;
	typedef enum logic [1:0] {K_READ, K_WRITE, K_RMW, K_REFRESH} kind_e;
	typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_PRE} st_e;

	// user request
	typedef struct packed {
		logic                 valid;
		op_e                  op;
		logic [ADDR_BITS-1:0] addr;
		logic                 wdata;
	} mem_req_s;

	// memory pins driven by the controller
	typedef struct packed {
		logic                 ce;
		logic                 select_b;
		logic                 write_b;
		logic [ADDR_BITS-1:0] cell_index;
		logic                 din;
	} dram_pins_s;

	function automatic logic [5:0] on_len(input kind_e k);
		case (k)
			K_WRITE: on_len = 6'(WRITE_ON_CYC);
			K_RMW:   on_len = 6'(RMW_ON_CYC);
			default: on_len = 6'(READ_ON_CYC);
		endcase
	endfunction

	function automatic logic [5:0] pre_len(input kind_e k);
		case (k)
			K_WRITE: pre_len = 6'(WRITE_PRE_CYC);
			K_RMW:   pre_len = 6'(RMW_PRE_CYC);
			default: pre_len = 6'(READ_PRE_CYC);
		endcase
	endfunction

endpackage
`default_nettype wire

// file: refresh_pacer.sv
`default_nettype none
module refresh_pacer
	import dram_pkg::*;
#(
	parameter int REF_STD_CYC  = REF_STD_DEF_CYC,
	parameter int REF_FAST_CYC = REF_FAST_DEF_CYC
)(
	input  wire logic                clk_i,
	input  wire logic                rst_b_i,
	input  wire logic                short_refresh_i,
	input  wire logic                ack_i,
	output logic                     due_o,
	output logic [ROW_BITS-1:0]      row_o
);

	localparam logic [REF_SLOT_BITS-1:0] SLOT_STD =
		REF_SLOT_BITS'(REF_STD_CYC / REF_ROWS);
	localparam logic [REF_SLOT_BITS-1:0] SLOT_FAST =
		REF_SLOT_BITS'(REF_FAST_CYC / REF_ROWS);

	logic [REF_SLOT_BITS-1:0] tick_ff;
	logic [REF_SLOT_BITS-1:0] nxt_tick;
	logic [REF_SLOT_BITS-1:0] slot;
	logic                     due_ff;
	logic                     nxt_due;
	logic [ROW_BITS-1:0]      row_ff;
	logic [ROW_BITS-1:0]      nxt_row;

	// slot per row: whole period over all rows, rounded down
	always_comb
	begin
		slot = short_refresh_i ? SLOT_FAST : SLOT_STD;
		nxt_tick = tick_ff + 16'h0001;
		nxt_due = due_ff;
		nxt_row = row_ff;
		if (tick_ff >= slot - 16'h0001)
		begin
			nxt_tick = 16'h0000;
		end
		if (ack_i)
		begin
			nxt_due = 1'b0;
			nxt_row = row_ff + 6'h01;
		end
		// a new slot beats a same-cycle ack, so no row is skipped
		if (tick_ff >= slot - 16'h0001)
		begin
			nxt_due = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			tick_ff <= 16'h0000;
			due_ff  <= 1'b0;
			row_ff  <= 6'h00;
		end
		else
		begin
			tick_ff <= nxt_tick;
			due_ff  <= nxt_due;
			row_ff  <= nxt_row;
		end
	end

	assign due_o = due_ff;
	assign row_o = row_ff;

	row_step_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ack_i |=> row_ff == $past(row_ff) + 6'h01)
		else $error("refresh row did not advance by one");

	slot_bound_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		short_refresh_i && $stable(short_refresh_i) |-> tick_ff < SLOT_FAST)
		else $error("refresh slot counter exceeded its bound");

endmodule
`default_nettype wire

// file: dram_ctrl.sv
`default_nettype none
// Notes on behaviour
// - refresh by reading each of 64 rows
// - every row within 2 ms, fast 1 ms
// - plastic slow grades need 1 ms period
// - read strobe 280 ns to 3000 ns
// - write strobe 480 ns to 3000 ns
// - read-modify-write cycle at least 840 ns
// - write wait never 50 to 170 ns
module dram_ctrl
	import dram_pkg::*;
#(
	parameter int REF_STD_CYC  = REF_STD_DEF_CYC,
	parameter int REF_FAST_CYC = REF_FAST_DEF_CYC
)(
	input  wire logic     clk_i,
	input  wire logic     rst_b_i,
	input  wire logic     short_refresh_i,
	input  wire mem_req_s req_i,
	output logic          req_ready_o,
	output logic          rdata_o,
	output logic          rdata_valid_o,
	output dram_pins_s    pins_o,
	input  wire logic     dout_i
);

	st_e                 state_ff;
	st_e                 nxt_state;
	kind_e               kind_ff;
	kind_e               nxt_kind;
	logic [5:0]          cnt_ff;
	logic [5:0]          nxt_cnt;
	dram_pins_s          pins_ff;
	dram_pins_s          nxt_pins;
	logic                ready_ff;
	logic                nxt_ready;
	logic                rdata_ff;
	logic                nxt_rdata;
	logic                valid_ff;
	logic                nxt_valid;
	logic                ref_due;
	logic                ref_ack;
	logic [ROW_BITS-1:0] ref_row;

	refresh_pacer #(
		.REF_STD_CYC  (REF_STD_CYC),
		.REF_FAST_CYC (REF_FAST_CYC)
	) u_pacer (
		.clk_i           (clk_i),
		.rst_b_i         (rst_b_i),
		.short_refresh_i (short_refresh_i),
		.ack_i           (ref_ack),
		.due_o           (ref_due),
		.row_o           (ref_row)
	);

	// cycle sequencer: idle, strobe high, precharge
	always_comb
	begin
		nxt_state = state_ff;
		nxt_kind = kind_ff;
		nxt_cnt = cnt_ff + 6'h01;
		nxt_pins = pins_ff;
		nxt_rdata = rdata_ff;
		nxt_valid = 1'b0;
		ref_ack = 1'b0;
		case (state_ff)
			ST_IDLE:
			begin
				nxt_cnt = 6'h00;
				// a request already offered is honoured before refresh
				if (ready_ff && req_i.valid)
				begin
					nxt_state = ST_ACTIVE;
					nxt_pins.ce = 1'b1;
					nxt_pins.select_b = 1'b0;
					nxt_pins.cell_index = req_i.addr;
					nxt_pins.din = req_i.wdata;
					case (req_i.op)
						OP_WRITE: nxt_kind = K_WRITE;
						OP_RMW:   nxt_kind = K_RMW;
						default:  nxt_kind = K_READ;
					endcase
					// write wait of zero, far below band
					nxt_pins.write_b = !(req_i.op == OP_WRITE &&
						WRITE_WAIT_CYC == 0);
				end
				else if (ref_due)
				begin
					ref_ack = 1'b1;
					nxt_state = ST_ACTIVE;
					nxt_kind = K_REFRESH;
					nxt_pins.ce = 1'b1;
					nxt_pins.select_b = 1'b1;
					nxt_pins.write_b = 1'b1;
					nxt_pins.cell_index = {6'h00, ref_row};
				end
			end
			ST_ACTIVE:
			begin
				// sample once access time has passed
				if (cnt_ff == 6'(ACC_CYC - 1) && kind_ff != K_REFRESH &&
					kind_ff != K_WRITE)
				begin
					nxt_rdata = dout_i;
					nxt_valid = 1'b1;
				end
				// modify phase starts at 300 ns, above band
				if (cnt_ff == 6'(ACC_CYC - 1) && kind_ff == K_RMW)
				begin
					nxt_pins.write_b = 1'b0;
				end
				if (cnt_ff == on_len(kind_ff) - 6'h01)
				begin
					nxt_state = ST_PRE;
					nxt_cnt = 6'h00;
					// output floats from here on, nothing sampled
					nxt_pins.ce = 1'b0;
					nxt_pins.write_b = 1'b1;
				end
			end
			ST_PRE:
			begin
				// full cycle time before the next strobe
				if (cnt_ff == pre_len(kind_ff) - 6'h01)
				begin
					nxt_state = ST_IDLE;
					nxt_cnt = 6'h00;
				end
			end
			default:
			begin
				nxt_state = ST_IDLE;
				nxt_cnt = 6'h00;
			end
		endcase
		// drop ready while refresh waits, so requests cannot starve it
		nxt_ready = (nxt_state == ST_IDLE) && !ref_due && !ref_ack;
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_ff <= ST_IDLE;
			kind_ff  <= K_READ;
			cnt_ff   <= 6'h00;
			pins_ff  <= '{ce: 1'b0, select_b: 1'b1, write_b: 1'b1,
				cell_index: 12'h000, din: 1'b0};
			ready_ff <= 1'b0;
			rdata_ff <= 1'b0;
			valid_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			kind_ff  <= nxt_kind;
			cnt_ff   <= nxt_cnt;
			pins_ff  <= nxt_pins;
			ready_ff <= nxt_ready;
			rdata_ff <= nxt_rdata;
			valid_ff <= nxt_valid;
		end
	end

	assign pins_o        = pins_ff;
	assign req_ready_o   = ready_ff;
	assign rdata_o       = rdata_ff;
	assign rdata_valid_o = valid_ff;

	// helper counters for checking: strobe width and rise-to-rise
	logic [7:0] hi_cnt_ff;
	logic [7:0] nxt_hi_cnt;
	logic [7:0] per_cnt_ff;
	logic [7:0] nxt_per_cnt;
	logic       ce_d_ff;

	always_comb
	begin
		nxt_hi_cnt = 8'h00;
		if (pins_ff.ce)
		begin
			nxt_hi_cnt = (hi_cnt_ff == 8'hff) ? 8'hff : hi_cnt_ff + 8'h01;
		end
		nxt_per_cnt = (per_cnt_ff == 8'hff) ? 8'hff : per_cnt_ff + 8'h01;
		if (pins_ff.ce && !ce_d_ff)
		begin
			nxt_per_cnt = 8'h01;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			hi_cnt_ff  <= 8'h00;
			per_cnt_ff <= 8'hff;
			ce_d_ff    <= 1'b0;
		end
		else
		begin
			hi_cnt_ff  <= nxt_hi_cnt;
			per_cnt_ff <= nxt_per_cnt;
			ce_d_ff    <= pins_ff.ce;
		end
	end

	sequence ce_up;
		$rose(pins_ff.ce);
	endsequence

	sequence ce_down;
		$fell(pins_ff.ce);
	endsequence

	read_width_a: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		ce_down and (kind_ff == K_READ || kind_ff == K_REFRESH) |->
		hi_cnt_ff >= READ_CE_MIN_CYC && hi_cnt_ff <= CE_MAX_CYC)
		else $error("read strobe width out of range");

	write_width_a: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		ce_down and (kind_ff == K_WRITE) |->
		hi_cnt_ff >= WRITE_CE_MIN_CYC && hi_cnt_ff <= CE_MAX_CYC)
		else $error("write strobe width out of range");

	rmw_spacing_a: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		ce_up and ($past(kind_ff) == K_RMW) |->
		per_cnt_ff >= RMW_CYCLE_CYC)
		else $error("next cycle started too soon after modify cycle");

	write_wait_a: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		$fell(pins_ff.write_b) |-> hi_cnt_ff <= WW_BAND_LO_CYC ||
		hi_cnt_ff >= WW_BAND_HI_CYC)
		else $error("write wait fell in forbidden band");

	sample_time_a: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		rdata_valid_o |-> hi_cnt_ff >= ACC_CYC && pins_ff.ce)
		else $error("read data sampled before access time");

	refresh_pins_a: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		ce_up and (kind_ff == K_REFRESH) |-> pins_ff.select_b &&
		pins_ff.write_b && pins_ff.cell_index[5:0] == $past(ref_row))
		else $error("refresh cycle pins wrong");

	refresh_served_a: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		ref_due |-> ##[0:60] ref_ack)
		else $error("pending refresh not served in time");

	// write strobe only under strobe and select
	write_gate_a: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		!pins_ff.write_b |-> pins_ff.ce && !pins_ff.select_b)
		else $error("write strobe outside a selected cycle");

endmodule
`default_nettype wire

// file: dram_model.sv
`default_nettype none
module dram_model
	import dram_pkg::*;
#(
	parameter int LIM_STD  = 6500,
	parameter int LIM_FAST = 3300
)(
	input  wire logic       clk_i,
	input  wire logic       fast_i,
	input  wire dram_pins_s pins_i,
	output logic            dout_o,
	output int              viol_o
);
	logic mem [4096];
	int   cnt;
	int   wdel;
	int   gap;
	logic rmw;
	int   age [REF_ROWS];

	// ones at start so a written zero is visible
	initial
	begin
		foreach (mem[i])
			mem[i] = 1'b1;
		foreach (age[i])
			age[i] = 0;
		cnt = 0;
		wdel = -1;
		gap = 0;
		rmw = 1'b0;
		viol_o = 0;
	end

	// wrong bit unless selected past access
	assign dout_o = (pins_i.ce && !pins_i.select_b && cnt >= ACC_CYC - 1)
		? mem[pins_i.cell_index] : !mem[pins_i.cell_index];

	// strobe widths, write wait and row ages
	always @(posedge clk_i)
	begin : track
		logic bad;
		int   ww;
		bad = 1'b0;
		ww = wdel * CLK_PERIOD_NS;
		gap <= gap + 1;
		foreach (age[i])
		begin
			age[i] <= age[i] + 1;
			if (age[i] > (fast_i ? LIM_FAST : LIM_STD))
				bad = 1'b1;
		end
		if (pins_i.ce)
		begin
			cnt <= cnt + 1;
			if (cnt == 0)
			begin
				bad |= rmw && gap < RMW_CYCLE_CYC;
				gap <= 1;
			end
			// write needs strobe and select low
			if (!pins_i.write_b && !pins_i.select_b)
				mem[pins_i.cell_index] <= pins_i.din;
			if (!pins_i.write_b && wdel < 0)
				wdel <= cnt;
		end
		else if (cnt > 0)
		begin
			bad |= cnt > CE_MAX_CYC;
			bad |= cnt < (wdel < 0 ? READ_CE_MIN_CYC :
				wdel == 0 ? WRITE_CE_MIN_CYC : RMW_CE_MIN_CYC);
			bad |= ww >= WW_BAND_LO_NS && ww <= WW_BAND_HI_NS;
			rmw <= wdel > 0;
			cnt <= 0;
			wdel <= -1;
			// any cycle restores its low-bit row
			age[pins_i.cell_index[ROW_BITS-1:0]] <= 0;
		end
		if (bad)
			viol_o <= viol_o + 1;
	end
endmodule
`default_nettype wire

// file: tb.sv
`default_nettype none
module tb
	import dram_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STD  = 6400;
	localparam int FAST = 3200;
	logic       clk;
	logic       rst_b;
	logic       fast;
	mem_req_s   req;
	logic       ready;
	logic       rdata;
	logic       rvalid;
	dram_pins_s pins;
	logic       dout;
	int         viol;
	int         mismatches = 0;
	int         check_count = 0;
	logic       shadow [4096];
	logic [11:0] addrs [5] = '{12'h000, 12'hfc0, 12'h03f, 12'hfff, 12'h5a5};

	dram_ctrl #(.REF_STD_CYC(STD), .REF_FAST_CYC(FAST)) uut (
		.clk_i           (clk),
		.rst_b_i         (rst_b),
		.short_refresh_i (fast),
		.req_i           (req),
		.req_ready_o     (ready),
		.rdata_o         (rdata),
		.rdata_valid_o   (rvalid),
		.pins_o          (pins),
		.dout_i          (dout)
	);

	dram_model #(.LIM_STD(STD + 100), .LIM_FAST(FAST + 100)) partner (
		.clk_i  (clk),
		.fast_i (fast),
		.pins_i (pins),
		.dout_o (dout),
		.viol_o (viol)
	);

	// free-running clock
	initial
	begin
		clk = 1'b0;
		forever
			#10 clk = ~clk;
	end

	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		if (mismatches == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// hold request until taken, then wait for read bit if any
	task automatic op(input op_e k, input logic [11:0] a, input logic d,
		output logic got);
		int n;
		@(negedge clk);
		req = '{1'b1, k, a, d};
		n = 0;
		while (ready !== 1'b1 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		check("request taken", ready, 1);
		@(negedge clk);
		req.valid = 1'b0;
		n = 0;
		while (k != OP_WRITE && rvalid !== 1'b1 && n < 60)
		begin
			@(negedge clk);
			n++;
		end
		if (k != OP_WRITE)
			check("read pulse", rvalid, 1);
		got = rdata;
	endtask

	task automatic t_reset;
		check("strobe in reset", pins.ce, 0);
		check("select in reset", pins.select_b, 1);
		check("write in reset", pins.write_b, 1);
		check("ready in reset", ready, 0);
	endtask

	task automatic t_write;
		logic got;
		foreach (addrs[i])
		begin
			shadow[addrs[i]] = i[0];
			op(OP_WRITE, addrs[i], i[0], got);
		end
	endtask

	// reading twice shows reads leave data alone
	task automatic t_read;
		logic got;
		repeat (2)
			foreach (addrs[i])
			begin
				op(OP_READ, addrs[i], 1'b0, got);
				check("read bit", got, shadow[addrs[i]]);
			end
	endtask

	// back to back read-modify-writes
	task automatic t_rmw;
		logic got;
		for (int i = 0; i < 4; i++)
		begin
			op(OP_RMW, addrs[i], !shadow[addrs[i]], got);
			check("rmw old bit", got, shadow[addrs[i]]);
			shadow[addrs[i]] = !shadow[addrs[i]];
		end
	endtask

	// idle span: every row at least once, deselected, at the chosen pace
	task automatic t_refresh(input logic f, input int span, input int max_n);
		logic [REF_ROWS-1:0] seen_rows;
		int   n;
		int   sel;
		int   rv;
		logic prev;
		@(negedge clk);
		fast = f;
		seen_rows = '0;
		n = 0;
		sel = 0;
		rv = 0;
		prev = pins.ce;
		repeat (span)
		begin
			@(negedge clk);
			if (pins.ce === 1'b1 && prev === 1'b0)
			begin
				n++;
				seen_rows[pins.cell_index[ROW_BITS-1:0]] = 1'b1;
				sel += (pins.select_b !== 1'b1);
			end
			rv += (rvalid === 1'b1);
			prev = pins.ce;
		end
		check("rows refreshed", seen_rows, {REF_ROWS{1'b1}});
		check("selected refresh", sel, 0);
		check("refresh pace", n <= max_n, 1);
		check("refresh data pulse", rv, 0);
	endtask

	// stop a hang well past the expected run length
	initial
	begin
		repeat (40000)
			@(posedge clk);
		mismatches++;
		report_and_stop;
	end

	initial
	begin
		rst_b = 1'b0;
		fast = 1'b1;
		req = '0;
		repeat (8)
			@(negedge clk);
		t_reset;
		rst_b = 1'b1;
		t_refresh(1'b1, FAST + 100, 66);
		t_write;
		t_read;
		t_rmw;
		t_refresh(1'b0, STD + 100, 66);
		t_read;
		check("device timing", viol, 0);
		report_and_stop;
	end
endmodule
`default_nettype wire
